//--- design/uwp_pkg.sv
// uwp_pkg: constants and types of the uart wake-up power control block
// Notes on behaviour
// - transport layer comes up enabled after every reset, no handshake needed.
// - only the host disable command turns the transport layer off.
// - a disabled transport layer returns only through the wake-up handshake.
// - on disable: drain pending traffic, send confirmation, then switch uart off.
// - while disabled, a falling edge on cts wakes the block.
// - outgoing traffic is held while the transport layer is disabled.
// - traffic pending while disabled asserts rts and raises the host wake indicator.
// - after device wake and host rts, confirmation goes out before held traffic.
// - on host wake the uart is enabled, rts and wake indicator asserted.
// - host wake is also answered by an enabled confirmation; host waits for it.
// - six power states derived from uart state and radio activity; clock need follows from them.
// - uart defaults to 9600 baud, one stop bit, no parity; reconfigurable.
// - event level none, standard, or standard plus acl; standard by default.
// - stored operation mode selects command or automatic; automatic by default.
// - up to three default remote devices stored; count is zero by default.
// - mask of serial ports to open at start-up, only lowest port by default.
// - link lost when no packets arrive for the link timeout, 20 s default.
// - inquiry scan discoverable, not, or limited; defaults discoverable and connectable.
// - command-mode packets start with byte 0x02 and end with byte 0x03.
package uwp_pkg;

  localparam int          CLK_HZ      = 200_000_000;
  localparam int          SEC_TIME_S  = 1;
  localparam logic [31:0] SEC_CYCLES  = 32'(CLK_HZ * SEC_TIME_S);

  localparam logic [7:0]  ADR_STATUS  = 8'h00;
  localparam logic [7:0]  ADR_MODE    = 8'h04;
  localparam logic [7:0]  ADR_UART    = 8'h08;
  localparam logic [7:0]  ADR_DEFCNT  = 8'h0c;
  localparam logic [7:0]  ADR_PORTS   = 8'h10;
  localparam logic [7:0]  ADR_LINKTO  = 8'h14;

  localparam int          MODE_AUTO   = 0;
  localparam int          MODE_EV_LO  = 1;
  localparam int          MODE_INQ_LO = 3;
  localparam int          MODE_PAGE   = 5;
  localparam int          UART_STOP2  = 24;
  localparam int          UART_PAREN  = 25;
  localparam int          UART_PARODD = 26;

  localparam logic [23:0] BAUD_RST    = 24'h002580;
  localparam logic [1:0]  EV_NONE     = 2'h0;
  localparam logic [1:0]  EV_STD      = 2'h1;
  localparam logic [1:0]  EV_ACL      = 2'h2;
  localparam logic [1:0]  INQ_DISC    = 2'h0;
  localparam logic [1:0]  INQ_LIMITED = 2'h2;
  localparam logic [1:0]  DEFCNT_RST  = 2'h0;
  localparam logic [7:0]  PORTS_RST   = 8'h01;
  localparam logic [15:0] LINKTO_RST  = 16'h0014;

  localparam logic [7:0]  FRAME_START = 8'h02;
  localparam logic [7:0]  FRAME_END   = 8'h03;
  localparam logic [7:0]  PKT_CONFIRM = 8'h43;
  localparam logic [2:0]  FRAME_LEN   = 3'h7;

  typedef enum logic [2:0] {
    ST_ON       = 3'h0,
    ST_DRAIN    = 3'h1,
    ST_CFM_OFF  = 3'h2,
    ST_OFF      = 3'h3,
    ST_DEV_WAKE = 3'h4,
    ST_CFM_ON   = 3'h5
  } uwp_tl_t;

  typedef enum logic [2:0] {
    PS_ALL_OFF    = 3'h0,
    PS_UART_ONLY  = 3'h1,
    PS_SCAN_UOFF  = 3'h2,
    PS_SCAN_UON   = 3'h3,
    PS_LINK_UOFF  = 3'h4,
    PS_LINK_UON   = 3'h5
  } uwp_ps_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } uwp_byte_t;

  typedef struct packed {
    logic        auto_mode;
    logic [1:0]  ev_level;
    logic [1:0]  inq_scan;
    logic        page_conn;
    logic [23:0] baud;
    logic        stop2;
    logic        par_en;
    logic        par_odd;
    logic [1:0]  def_cnt;
    logic [7:0]  ports;
    logic [15:0] link_to_s;
  } uwp_cfg_t;

endpackage : uwp_pkg

//--- design/uwp_ctrl.sv
// uwp_ctrl: transport-layer power control, wake handshake and stored settings
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module uwp_ctrl #(
  parameter logic [7:0]  OPC_TL_OFF = 8'h01,
  parameter logic [7:0]  OPC_TL_ON  = 8'h02,
  parameter logic [31:0] CYC_PER_SEC = uwp_pkg::SEC_CYCLES
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // host pins
  input  wire logic              cts_n,
  output logic                   rts_n,
  output logic                   host_wake_indicator,
  // uart transmitter
  output uwp_pkg::uwp_byte_t     uart_tx,
  input  wire logic              uart_tx_ready,
  output logic                   uart_en,
  // firmware side
  input  wire uwp_pkg::uwp_byte_t fw_tx,
  output logic                   fw_tx_ready,
  input  wire logic              fw_buf_empty,
  input  wire logic              tl_off_cmd,
  input  wire logic [1:0]        radio_mode,
  input  wire logic              link_up,
  input  wire logic              pkt_rx,
  output logic                   link_lost,
  // power and settings
  output uwp_pkg::uwp_ps_t       power_state,
  output logic                   ref_clk_en,
  output uwp_pkg::uwp_cfg_t      cfg
);

  uwp_pkg::uwp_tl_t   st_ff;
  uwp_pkg::uwp_tl_t   nxt_st;
  uwp_pkg::uwp_byte_t otx_ff;
  uwp_pkg::uwp_cfg_t  cfg_ff;
  uwp_pkg::uwp_ps_t   ps;
  logic [2:0]         idx_ff;
  logic               cts_s1_ff;
  logic               cts_s2_ff;
  logic               cts_d_ff;
  logic               cts_fall;
  logic               rts_n_ff;
  logic               wake_ff;
  logic               load;
  logic               in_cfm;
  logic               src_valid;
  logic [7:0]         src_data;
  logic [7:0]         frm_opc;
  logic               frm_done;
  logic [31:0]        pre_ff;
  logic [15:0]        sec_ff;
  logic               lost_ff;
  logic [31:0]        rdata_ff;

  // byte of a short confirmation frame with empty payload
  function automatic logic [7:0] frame_byte(input logic [2:0] i,
                                            input logic [7:0] opc);
    logic [7:0] chk;
    chk = uwp_pkg::PKT_CONFIRM + opc;
    case (i)
      3'h0:    frame_byte = uwp_pkg::FRAME_START;
      3'h1:    frame_byte = uwp_pkg::PKT_CONFIRM;
      3'h2:    frame_byte = opc;
      3'h5:    frame_byte = chk;
      3'h6:    frame_byte = uwp_pkg::FRAME_END;
      default: frame_byte = 8'h00;
    endcase
  endfunction : frame_byte

  // reserved code 3 of a two-bit selector is refused
  function automatic logic legal2(input logic [1:0] v);
    legal2 = (v != 2'h3);
  endfunction : legal2

  // cts comes from the host pin: two flops before anything looks at it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cts_s1_ff <= 1'b1;
      cts_s2_ff <= 1'b1;
      cts_d_ff  <= 1'b1;
    end
    else
    begin
      cts_s1_ff <= cts_n;
      cts_s2_ff <= cts_s1_ff;
      cts_d_ff  <= cts_s2_ff;
    end
  end

  assign cts_fall = cts_d_ff & ~cts_s2_ff;

  assign in_cfm   = (st_ff == uwp_pkg::ST_CFM_OFF) || (st_ff == uwp_pkg::ST_CFM_ON);
  assign load     = ~otx_ff.valid | uart_tx_ready;
  assign frm_opc  = (st_ff == uwp_pkg::ST_CFM_OFF) ? OPC_TL_OFF : OPC_TL_ON;
  assign frm_done = (idx_ff == uwp_pkg::FRAME_LEN);

  // transport-layer state
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      uwp_pkg::ST_ON:
        if (tl_off_cmd)
          nxt_st = uwp_pkg::ST_DRAIN;
      uwp_pkg::ST_DRAIN:
        if (fw_buf_empty && !fw_tx.valid)
          nxt_st = uwp_pkg::ST_CFM_OFF;
      uwp_pkg::ST_CFM_OFF:
        if (frm_done && load)
          nxt_st = uwp_pkg::ST_OFF;
      uwp_pkg::ST_OFF:
        if (cts_fall)
          nxt_st = uwp_pkg::ST_CFM_ON;
        else if (fw_tx.valid)
          nxt_st = uwp_pkg::ST_DEV_WAKE;
      uwp_pkg::ST_DEV_WAKE:
        if (!cts_s2_ff)
          nxt_st = uwp_pkg::ST_CFM_ON;
      uwp_pkg::ST_CFM_ON:
        if (frm_done && load)
          nxt_st = uwp_pkg::ST_ON;
      default:
        nxt_st = uwp_pkg::ST_ON;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      st_ff <= uwp_pkg::ST_ON;
    else
      st_ff <= nxt_st;
  end

  // pins follow the next state so they change with it, not a cycle late
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rts_n_ff <= 1'b0;
      wake_ff  <= 1'b1;
    end
    else
    begin
      rts_n_ff <= (nxt_st == uwp_pkg::ST_OFF) || (nxt_st == uwp_pkg::ST_CFM_OFF);
      wake_ff  <= (nxt_st != uwp_pkg::ST_OFF);
    end
  end

  assign rts_n               = rts_n_ff;
  assign host_wake_indicator = wake_ff;
  assign uart_en             = (st_ff != uwp_pkg::ST_OFF) && (st_ff != uwp_pkg::ST_DEV_WAKE);

  // outgoing byte source: firmware only while enabled, frames in confirm states
  always_comb
  begin
    src_valid = 1'b0;
    src_data  = 8'h00;
    if (in_cfm && !frm_done)
    begin
      src_valid = 1'b1;
      src_data  = frame_byte(idx_ff, frm_opc);
    end
    else if ((st_ff == uwp_pkg::ST_ON) || (st_ff == uwp_pkg::ST_DRAIN))
    begin
      src_valid = fw_tx.valid;
      src_data  = fw_tx.data;
    end
  end

  // held traffic waits in the firmware; nothing is dropped here
  assign fw_tx_ready = load &&
                       ((st_ff == uwp_pkg::ST_ON) || (st_ff == uwp_pkg::ST_DRAIN));

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      idx_ff <= 3'h0;
    else if (!in_cfm)
      idx_ff <= 3'h0;
    else if (load && !frm_done)
      idx_ff <= idx_ff + 3'h1;
    else if (load && frm_done)
      idx_ff <= 3'h0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      otx_ff <= '0;
    else if (load)
    begin
      otx_ff.valid <= src_valid;
      otx_ff.data  <= src_data;
    end
  end

  assign uart_tx = otx_ff;

  // power state from uart activity and radio activity
  always_comb
  begin
    case (radio_mode)
      2'h0:    ps = uart_en ? uwp_pkg::PS_UART_ONLY : uwp_pkg::PS_ALL_OFF;
      2'h1:    ps = uart_en ? uwp_pkg::PS_SCAN_UON  : uwp_pkg::PS_SCAN_UOFF;
      default: ps = uart_en ? uwp_pkg::PS_LINK_UON  : uwp_pkg::PS_LINK_UOFF;
    endcase
  end

  // reference clock requested in every power state except PS_ALL_OFF
  assign power_state = ps;
  assign ref_clk_en  = (ps != uwp_pkg::PS_ALL_OFF);

  // link supervision: whole seconds without a packet
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pre_ff <= 32'h0;
      sec_ff <= 16'h0;
    end
    else if (!link_up || pkt_rx)
    begin
      pre_ff <= 32'h0;
      sec_ff <= 16'h0;
    end
    else if (pre_ff == CYC_PER_SEC - 32'h1)
    begin
      pre_ff <= 32'h0;
      if (sec_ff != cfg_ff.link_to_s)
        sec_ff <= sec_ff + 16'h1;
    end
    else
      pre_ff <= pre_ff + 32'h1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      lost_ff <= 1'b0;
    else
      lost_ff <= link_up && !pkt_rx && (cfg_ff.link_to_s != 16'h0) &&
                 (pre_ff == CYC_PER_SEC - 32'h1) &&
                 (sec_ff == cfg_ff.link_to_s - 16'h1);
  end

  assign link_lost = lost_ff;

  // stored start-up settings
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_ff.auto_mode <= 1'b1;
      cfg_ff.ev_level  <= uwp_pkg::EV_STD;
      cfg_ff.inq_scan  <= uwp_pkg::INQ_DISC;
      cfg_ff.page_conn <= 1'b1;
      cfg_ff.baud      <= uwp_pkg::BAUD_RST;
      cfg_ff.stop2     <= 1'b0;
      cfg_ff.par_en    <= 1'b0;
      cfg_ff.par_odd   <= 1'b0;
      cfg_ff.def_cnt   <= uwp_pkg::DEFCNT_RST;
      cfg_ff.ports     <= uwp_pkg::PORTS_RST;
      cfg_ff.link_to_s <= uwp_pkg::LINKTO_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        uwp_pkg::ADR_MODE:
        begin
          cfg_ff.auto_mode <= reg_wdata[uwp_pkg::MODE_AUTO];
          if (legal2(reg_wdata[uwp_pkg::MODE_EV_LO +: 2]))
            cfg_ff.ev_level <= reg_wdata[uwp_pkg::MODE_EV_LO +: 2];
          if (legal2(reg_wdata[uwp_pkg::MODE_INQ_LO +: 2]))
            cfg_ff.inq_scan <= reg_wdata[uwp_pkg::MODE_INQ_LO +: 2];
          cfg_ff.page_conn <= reg_wdata[uwp_pkg::MODE_PAGE];
        end
        uwp_pkg::ADR_UART:
        begin
          cfg_ff.baud    <= reg_wdata[23:0];
          cfg_ff.stop2   <= reg_wdata[uwp_pkg::UART_STOP2];
          cfg_ff.par_en  <= reg_wdata[uwp_pkg::UART_PAREN];
          cfg_ff.par_odd <= reg_wdata[uwp_pkg::UART_PARODD];
        end
        uwp_pkg::ADR_DEFCNT:
          cfg_ff.def_cnt <= reg_wdata[1:0];
        uwp_pkg::ADR_PORTS:
          cfg_ff.ports <= reg_wdata[7:0];
        uwp_pkg::ADR_LINKTO:
          cfg_ff.link_to_s <= reg_wdata[15:0];
        default:
          cfg_ff.ports <= cfg_ff.ports;
      endcase
    end
  end

  assign cfg = cfg_ff;

  // read data stands for exactly one cycle; unmapped reads give zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata_ff <= 32'h0;
    else if (!reg_rd)
      rdata_ff <= 32'h0;
    else
    begin
      case (reg_addr)
        uwp_pkg::ADR_STATUS:
          rdata_ff <= {21'h0, wake_ff, ~rts_n_ff, uart_en, 2'h0, ps, st_ff};
        uwp_pkg::ADR_MODE:
          rdata_ff <= {26'h0, cfg_ff.page_conn, cfg_ff.inq_scan,
                       cfg_ff.ev_level, cfg_ff.auto_mode};
        uwp_pkg::ADR_UART:
          rdata_ff <= {5'h0, cfg_ff.par_odd, cfg_ff.par_en, cfg_ff.stop2, cfg_ff.baud};
        uwp_pkg::ADR_DEFCNT:
          rdata_ff <= {30'h0, cfg_ff.def_cnt};
        uwp_pkg::ADR_PORTS:
          rdata_ff <= {24'h0, cfg_ff.ports};
        uwp_pkg::ADR_LINKTO:
          rdata_ff <= {16'h0, cfg_ff.link_to_s};
        default:
          rdata_ff <= 32'h0;
      endcase
    end
  end

  assign reg_rdata = rdata_ff;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_off_seen;
    st_ff == uwp_pkg::ST_OFF;
  endsequence

  sequence s_leave_off;
    s_off_seen ##1 (st_ff != uwp_pkg::ST_OFF);
  endsequence

  sequence s_frame_first;
    in_cfm && load && (idx_ff == 3'h0);
  endsequence

  AST_UP_ENABLED: assert property ($past(reset) |-> st_ff == uwp_pkg::ST_ON)
    else $error("transport layer not enabled after reset");

  AST_NO_SELF_OFF: assert property ($fell(uart_en) |->
    $past(st_ff) == uwp_pkg::ST_CFM_OFF) else $error("uart switched off without confirmation");

  AST_WAKE_ONLY: assert property (s_leave_off |-> (st_ff == uwp_pkg::ST_CFM_ON) ||
    (st_ff == uwp_pkg::ST_DEV_WAKE)) else $error("left off state without wake handshake");

  AST_DRAIN_FIRST: assert property ((st_ff == uwp_pkg::ST_CFM_OFF) |->
    ($past(st_ff) == uwp_pkg::ST_DRAIN) || ($past(st_ff) == uwp_pkg::ST_CFM_OFF))
    else $error("disable confirmation before drain");

  AST_CTS_WAKE: assert property ((s_off_seen and cts_fall) |=>
    st_ff == uwp_pkg::ST_CFM_ON ##0 uart_en && !rts_n && host_wake_indicator)
    else $error("cts falling edge did not wake the uart");

  AST_HOLD: assert property (!uart_en |-> !fw_tx_ready && !(load && src_valid))
    else $error("traffic sent while transport disabled");

  AST_DEV_WAKE: assert property ((s_off_seen and fw_tx.valid && !cts_fall) |=>
    !rts_n && host_wake_indicator && !uart_en)
    else $error("device wake did not raise rts and indicator");

  AST_CFM_BEFORE_DATA: assert property ((st_ff == uwp_pkg::ST_DEV_WAKE) &&
    !cts_s2_ff |=> !fw_tx_ready [*2]) else $error("held traffic passed before confirmation");

  AST_FRAME_DELIM: assert property (s_frame_first |=>
    otx_ff.valid && otx_ff.data == 8'h02) else $error("frame does not open with start byte");

  AST_WAKE_LOW: assert property ((st_ff == uwp_pkg::ST_OFF) |->
    !host_wake_indicator && rts_n) else $error("wake indicator high while disabled");

  AST_LOST_ONCE: assert property (link_lost |=> !link_lost)
    else $error("link lost pulse longer than one cycle");

endmodule : uwp_ctrl

`default_nettype wire

//--- sim/uwp_host_model.sv
// uwp_host_model: host processor side of the uart link with rts/cts wake
`timescale 1ns/100ps
`default_nettype none

module uwp_host_model (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // device pins
  input  wire logic               rts_n,
  output logic                    cts_n,
  // uart receive side
  input  wire uwp_pkg::uwp_byte_t uart_tx,
  output logic                    uart_tx_ready,
  output logic                    rx_valid,
  output logic [7:0]              rx_data,
  // test controls
  input  wire logic               slow,
  input  wire logic               deaf,
  input  wire logic               wake_req
);
  logic       cts_n_ff;
  logic [1:0] pace_ff;

  // host rts: own wish to talk, or answer to the device asking for a wake
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cts_n_ff <= 1'b1;
    else
      cts_n_ff <= ~(wake_req | (~rts_n & ~deaf));
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pace_ff <= 2'h0;
    else
      pace_ff <= pace_ff + 2'h1;
  end

  assign cts_n         = cts_n_ff;
  // a slow host takes one byte in four, stalling the transmitter
  assign uart_tx_ready = ~slow | (pace_ff == 2'h3);
  assign rx_valid      = uart_tx.valid & uart_tx_ready;
  assign rx_data       = uart_tx.data; // receive only, never sends a break

endmodule : uwp_host_model
`default_nettype wire

//--- sim/uwp_ctrl_tb.sv
// uwp_ctrl_tb: self-checking bench for the uart wake-up power control
`timescale 1ns/100ps
`default_nettype none

module uwp_ctrl_tb;
  logic               clk = 1'b0;
  logic               reset = 1'b1;
  logic [7:0]         reg_addr = 8'h00;
  logic [31:0]        reg_wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [31:0]        reg_rdata;
  logic               cts_n, rts_n, host_wake_indicator, uart_tx_ready, uart_en;
  logic               fw_tx_ready, link_lost, ref_clk_en, rx_valid;
  uwp_pkg::uwp_byte_t uart_tx;
  uwp_pkg::uwp_byte_t fw_tx = 9'h000;
  uwp_pkg::uwp_ps_t   power_state;
  uwp_pkg::uwp_cfg_t  cfg;
  logic               fw_buf_empty = 1'b1;
  logic               tl_off_cmd = 1'b0;
  logic [1:0]         radio_mode = 2'h0;
  logic               link_up = 1'b0, pkt_rx = 1'b0, slow = 1'b0, deaf = 1'b0;
  logic               wake_req = 1'b0, rd_q = 1'b0;
  logic [7:0]         rx_data;
  logic [1:0]         ev, inq;
  logic [31:0]        w;
  logic [31:0]        seed = 32'h0000000c;
  logic [31:0]        rq[$];
  logic [7:0]         bq[$];
  int                 fail_count = 0, checked = 0, lost_cnt = 0;

  always #2.5 clk = ~clk;

  uwp_ctrl #(.CYC_PER_SEC(32'h00000014)) i_uwp_ctrl (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cts_n(cts_n),
    .rts_n(rts_n), .host_wake_indicator(host_wake_indicator), .uart_tx(uart_tx),
    .uart_tx_ready(uart_tx_ready), .uart_en(uart_en), .fw_tx(fw_tx),
    .fw_tx_ready(fw_tx_ready), .fw_buf_empty(fw_buf_empty), .tl_off_cmd(tl_off_cmd),
    .radio_mode(radio_mode), .link_up(link_up), .pkt_rx(pkt_rx), .link_lost(link_lost),
    .power_state(power_state), .ref_clk_en(ref_clk_en), .cfg(cfg));

  uwp_host_model i_uwp_host_model (
    .clk(clk), .reset(reset), .rts_n(rts_n), .cts_n(cts_n), .uart_tx(uart_tx),
    .uart_tx_ready(uart_tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .slow(slow), .deaf(deaf), .wake_req(wake_req));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
  begin
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  end
  endtask : chk

  task automatic end_sim;
  begin
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask : end_sim

  task automatic timeout(input string name);
  begin
    chk(name, 32'h0, 32'h1);
    end_sim();
  end
  endtask : timeout

  function automatic logic [31:0] xs();
  begin
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  end
  endfunction : xs

  task automatic tick(input int n);
  begin
    repeat (n) @(posedge clk);
  end
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
  begin
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
  begin
    rq.push_back(exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
  end
  endtask : rd

  // byte is noted as expected before it is offered
  task automatic send(input logic [7:0] d);
    int n = 0;
  begin
    bq.push_back(d);
    fw_tx <= {1'b1, d};
    @(posedge clk);
    while (fw_tx_ready !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 500)
      timeout("send");
    fw_tx.valid <= 1'b0;
    @(posedge clk);
  end
  endtask : send

  task automatic frame(input logic [7:0] opc);
    logic [55:0] f;
  begin
    f = {8'h02, 8'h43, opc, 16'h0000, 8'h43 + opc, 8'h03};
    for (int k = 6; k >= 0; k--)
      bq.push_back(f[k*8 +: 8]);
  end
  endtask : frame

  task automatic wait_en(input logic v);
    int n = 0;
  begin
    while (uart_en !== v && n < 800)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 800)
      timeout("uart_en wait");
  end
  endtask : wait_en

  task automatic wait_q;
    int n = 0;
  begin
    while (bq.size() != 0 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 2000)
      timeout("byte wait");
  end
  endtask : wait_q

  // result watcher: oldest note against what appears at the outputs
  always @(posedge clk)
  begin
    if (rd_q)
      chk("reg_rdata", reg_rdata, rq.pop_front());
    if (rx_valid === 1'b1)
      chk("uart byte", {24'h0, rx_data},
          bq.size() ? {24'h0, bq.pop_front()} : 32'hxxxxxxxx);
    if (link_lost === 1'b1)
      lost_cnt++;
    rd_q <= reg_rd;
  end

  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    tick(2);
    chk("uart_en", 32'(uart_en), 32'h1);
    chk("cfg baud", 32'(cfg.baud), 32'h00002580);
    chk("cfg ports", 32'(cfg.ports), 32'h00000001);
    chk("cfg auto", 32'(cfg.auto_mode), 32'h00000001);
    rd(uwp_pkg::ADR_STATUS, 32'h00000708);
    rd(uwp_pkg::ADR_MODE, 32'h00000023);
    rd(uwp_pkg::ADR_UART, 32'h00002580);
    rd(uwp_pkg::ADR_DEFCNT, 32'h0);
    rd(uwp_pkg::ADR_PORTS, 32'h1);
    rd(uwp_pkg::ADR_LINKTO, 32'h14);
    rd(8'h20, 32'h0);
    ev  = 2'h1;
    inq = 2'h0;
    // code 3 of either selector is reserved and must leave the field alone
    for (int e = 0; e < 4; e++)
      for (int i = 0; i < 4; i++)
      begin
        wr(uwp_pkg::ADR_MODE, {26'h0, 1'b1, 2'(i), 2'(e), 1'b0});
        if (e != 3)
          ev = 2'(e);
        if (i != 3)
          inq = 2'(i);
        rd(uwp_pkg::ADR_MODE, {26'h0, 1'b1, inq, ev, 1'b0});
      end
    w = xs() & 32'h07ffffff;
    wr(uwp_pkg::ADR_UART, w);
    rd(uwp_pkg::ADR_UART, w);
    w = xs() & 32'h000000ff;
    wr(uwp_pkg::ADR_PORTS, w);
    chk("cfg ports", 32'(cfg.ports), w);
    rd(uwp_pkg::ADR_PORTS, w);
    wr(uwp_pkg::ADR_DEFCNT, 32'h3);
    rd(uwp_pkg::ADR_DEFCNT, 32'h3);
    $display("test registers done");
    slow <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      w = xs();
      send(w[7:0]);
    end
    wait_q();
    slow <= 1'b0;
    for (int r = 0; r < 4; r++)
    begin
      radio_mode <= 2'(r);
      tick(2);
      chk("power_state", 32'(power_state), 32'(2 * (r == 3 ? 2 : r) + 1));
    end
    fw_buf_empty <= 1'b0;
    tl_off_cmd   <= 1'b1;
    tick(1);
    tl_off_cmd   <= 1'b0;
    tick(20);
    chk("uart_en drain", 32'(uart_en), 32'h1);
    frame(8'h01);
    fw_buf_empty <= 1'b1;
    wait_en(1'b0);
    chk("left bytes", 32'(bq.size()), 32'h0);
    tick(2);
    chk("rts_n off", 32'(rts_n), 32'h1);
    chk("wake off", 32'(host_wake_indicator), 32'h0);
    for (int r = 0; r < 4; r++)
    begin
      radio_mode <= 2'(r);
      tick(2);
      chk("power_state", 32'(power_state), 32'(2 * (r == 3 ? 2 : r)));
      chk("ref_clk_en", 32'(ref_clk_en), 32'(r != 0));
    end
    tick(50);
    chk("uart_en stays off", 32'(uart_en), 32'h0);
    $display("test disable done");
    frame(8'h02);
    wake_req <= 1'b1;
    wait_en(1'b1);
    chk("rts_n host wake", 32'(rts_n), 32'h0);
    chk("wake host wake", 32'(host_wake_indicator), 32'h1);
    wait_q();
    wake_req <= 1'b0;
    $display("test host wake done");
    frame(8'h01);
    tl_off_cmd <= 1'b1;
    tick(1);
    tl_off_cmd <= 1'b0;
    wait_en(1'b0);
    wait_q();
    deaf <= 1'b1;
    frame(8'h02);
    w = xs();
    fork
      send(w[7:0]);
      begin
        tick(10);
        chk("rts_n dev wake", 32'(rts_n), 32'h0);
        chk("wake dev wake", 32'(host_wake_indicator), 32'h1);
        chk("uart held", 32'(uart_en), 32'h0);
        deaf <= 1'b0;
      end
    join
    wait_q();
    $display("test device wake done");
    wr(uwp_pkg::ADR_LINKTO, 32'h2);
    chk("cfg link timeout", 32'(cfg.link_to_s), 32'h2);
    lost_cnt = 0;
    link_up <= 1'b1;
    tick(30);
    pkt_rx <= 1'b1;
    tick(1);
    pkt_rx <= 1'b0;
    tick(30);
    chk("link_lost early", 32'(lost_cnt), 32'h0);
    tick(90);
    chk("link_lost count", 32'(lost_cnt), 32'h1);
    // a zero timeout switches supervision off
    wr(uwp_pkg::ADR_LINKTO, 32'h0);
    lost_cnt = 0;
    tick(60);
    chk("link_lost off", 32'(lost_cnt), 32'h0);
    $display("test link timeout done");
    end_sim();
  end

endmodule : uwp_ctrl_tb
`default_nettype wire
